// ---- rtl/sso_cfg.svh ----
// Notes on behaviour
// - standstill violation latches error, torque off
// - error clears the no-functional-error output
// - request, delay, supervise decel, then pulses off
// - both disable outputs low in the safe state sets safe bit
// - configurable ramp slope, default 1073676289
// - ramp supervision selectable, on by default
// - early limit end selectable, off by default
// - monitoring time in us, default 0
// - request delay in us, default 0
// - early limit time in us, default 0
// - monitoring timer starts after request delay
// - ramp checking starts after request delay
// - ramp starts at active limit, falls at slope
// - ramp at tolerance or time out ends stop
// - speed under tolerance long enough ends early
// - speed above ramp limit means error
// - ramp mode without good encoder means error
// - time only, or time plus ramp supervised
// - time mode: delay plus time, then off
`ifndef SSO_CFG_SVH
`define SSO_CFG_SVH
`define SSO_SLOPE_RST     32'h3fff0001
`define SSO_RAMP_EN_RST   1'b1
`define SSO_EARLY_EN_RST  1'b0
`define SSO_TIME_RST      32'h00000000
`define SSO_A_SLOPE       8'h00
`define SSO_A_CTRL        8'h04
`define SSO_A_TMON        8'h08
`define SSO_A_TDLY        8'h0c
`define SSO_A_TERL        8'h10
`define SSO_A_STAT        8'h14
`define SSO_A_TOL         8'h18
`define SSO_CLK_MHZ       10
`define SSO_US_CYCLES     `SSO_CLK_MHZ
`endif

// ---- rtl/sso_pkg.sv ----
package sso_pkg;
  typedef enum logic [2:0] {
    SSO_IDLE  = 3'b000,
    SSO_DELAY = 3'b001,
    SSO_SUPV  = 3'b010,
    SSO_SAFE  = 3'b011,
    SSO_FAIL  = 3'b100
  } sso_state_e;
  typedef logic [31:0] sso_word_t;
endpackage

// ---- rtl/sso_tick_if.sv ----
`timescale 1ns/1ps
interface sso_tick_if;
  logic us_tick;
  modport src (output us_tick);
  modport dst (input us_tick);
endinterface

// ---- rtl/sso_us_tick.sv ----
`timescale 1ns/1ps
`include "sso_cfg.svh"
module sso_us_tick #(
  parameter int CYCLES = `SSO_US_CYCLES
) (
  input  wire logic clk_i,
  input  wire logic arst_n_i,
  sso_tick_if.src   tick
);
  localparam int W = $clog2(CYCLES + 1);
  logic [W-1:0] cnt_reg;
  logic [W-1:0] cnt_next;
  logic         tick_reg;
  logic         tick_next;
  // refused at elaboration: a zero divider would never produce a tick
  if (CYCLES < 1) begin : g_bad_cycles
    $error("sso_us_tick: CYCLES must be at least 1");
  end
  always_comb begin
    tick_next = 1'b0;
    cnt_next  = cnt_reg + {{(W-1){1'b0}}, 1'b1};
    if (cnt_reg == W'(CYCLES - 1)) begin
      cnt_next  = '0;
      tick_next = 1'b1;
    end
  end
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_reg  <= '0;
      tick_reg <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      tick_reg <= tick_next;
    end
  end
  assign tick.us_tick = tick_reg;
endmodule

// ---- rtl/sso_monitor.sv ----
`timescale 1ns/1ps
`include "sso_cfg.svh"
module sso_monitor #(
  parameter int SW = 32
) (
  input  wire logic          clk_i,
  input  wire logic          arst_n_i,
  input  wire logic [7:0]    addr_i,
  input  wire logic [31:0]   wdata_i,
  input  wire logic          wr_i,
  input  wire logic          rd_i,
  output logic      [31:0]   rdata_o,
  input  wire logic          stop_req_i,
  input  wire logic          ack_i,
  input  wire logic [SW-1:0] speed_i,
  input  wire logic [SW-1:0] speed_limit_i,
  input  wire logic          encoder_ok_i,
  input  wire logic          standstill_viol_i,
  output logic               pulse_hi_en_o,
  output logic               pulse_lo_en_o,
  output logic               safe_state_o,
  output logic               no_functional_error_out_o,
  output logic               fail_o
);
  // ***********************************************
  // register map
  // ***********************************************
  localparam logic [7:0] A_SLOPE = `SSO_A_SLOPE;
  localparam logic [7:0] A_CTRL  = `SSO_A_CTRL;
  localparam logic [7:0] A_TMON  = `SSO_A_TMON;
  localparam logic [7:0] A_TDLY  = `SSO_A_TDLY;
  localparam logic [7:0] A_TERL  = `SSO_A_TERL;
  localparam logic [7:0] A_STAT  = `SSO_A_STAT;
  localparam logic [7:0] A_TOL   = `SSO_A_TOL;

  // refused at elaboration: the tolerance register and read port hold at most one word
  if (SW < 8 || SW > 32) begin : g_bad_width
    $error("sso_monitor: SW must be 8..32");
  end

  sso_tick_if tk ();
  sso_us_tick #(.CYCLES(`SSO_US_CYCLES)) u_tick (
    .clk_i    (clk_i),
    .arst_n_i (arst_n_i),
    .tick     (tk)
  );

  sso_pkg::sso_word_t slope_reg, slope_next;
  sso_pkg::sso_word_t tmon_reg, tmon_next;
  sso_pkg::sso_word_t tdly_reg, tdly_next;
  sso_pkg::sso_word_t terl_reg, terl_next;
  logic [SW-1:0]      tol_reg, tol_next;
  logic               ramp_en_reg, ramp_en_next;
  logic               early_en_reg, early_en_next;
  logic [31:0]        rdata_reg, rdata_next;

  // ***********************************************
  // configuration registers
  // ***********************************************
  always_comb begin
    slope_next    = slope_reg;
    tmon_next     = tmon_reg;
    tdly_next     = tdly_reg;
    terl_next     = terl_reg;
    tol_next      = tol_reg;
    ramp_en_next  = ramp_en_reg;
    early_en_next = early_en_reg;
    if (wr_i) begin
      case (addr_i)
        A_SLOPE: slope_next = wdata_i;
        A_CTRL: begin
          ramp_en_next  = wdata_i[0];
          early_en_next = wdata_i[1];
        end
        A_TMON: tmon_next = wdata_i;
        A_TDLY: tdly_next = wdata_i;
        A_TERL: terl_next = wdata_i;
        A_TOL:  tol_next  = wdata_i[SW-1:0];
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      slope_reg    <= `SSO_SLOPE_RST;
      tmon_reg     <= `SSO_TIME_RST;
      tdly_reg     <= `SSO_TIME_RST;
      terl_reg     <= `SSO_TIME_RST;
      tol_reg      <= '0;
      ramp_en_reg  <= `SSO_RAMP_EN_RST;
      early_en_reg <= `SSO_EARLY_EN_RST;
    end else begin
      slope_reg    <= slope_next;
      tmon_reg     <= tmon_next;
      tdly_reg     <= tdly_next;
      terl_reg     <= terl_next;
      tol_reg      <= tol_next;
      ramp_en_reg  <= ramp_en_next;
      early_en_reg <= early_en_next;
    end
  end

  // ***********************************************
  // stop sequencing
  // ***********************************************
  sso_pkg::sso_state_e st_reg, st_next;
  logic [31:0]         tim_reg, tim_next;
  logic [31:0]         erl_reg, erl_next;
  logic [SW+31:0]      lim_reg, lim_next;
  logic                phi_reg, phi_next;
  logic                plo_reg, plo_next;
  logic                safe_reg, safe_next;
  logic                nfe_reg, nfe_next;
  logic                fail_reg, fail_next;
  logic [SW+31:0]      speed_x;
  logic [SW+31:0]      tol_x;
  logic [SW+31:0]      dec_x;
  logic                ramp_done;
  logic                viol;

  // slope is per s^2; spread it evenly over each microsecond tick
  assign speed_x = {speed_i, 32'h00000000};
  assign tol_x   = {tol_reg, 32'h00000000};
  assign dec_x   = {{SW{1'b0}}, slope_reg} * (SW + 32)'(4295);
  assign ramp_done = (lim_reg <= tol_x);
  assign viol      = standstill_viol_i;

  always_comb begin
    st_next   = st_reg;
    tim_next  = tim_reg;
    erl_next  = erl_reg;
    lim_next  = lim_reg;
    phi_next  = 1'b1;
    plo_next  = 1'b1;
    case (st_reg)
      sso_pkg::SSO_IDLE: begin
        if (stop_req_i) begin
          tim_next = '0;
          if (ramp_en_reg && !encoder_ok_i) begin
            st_next = sso_pkg::SSO_FAIL;
          end else begin
            st_next = sso_pkg::SSO_DELAY;
          end
        end
      end
      sso_pkg::SSO_DELAY: begin
        if (tk.us_tick) begin
          tim_next = tim_reg + 32'h00000001;
        end
        if (tim_reg >= tdly_reg) begin
          st_next  = sso_pkg::SSO_SUPV;
          tim_next = '0;
          erl_next = '0;
          lim_next = {speed_limit_i, 32'h00000000};
        end
      end
      sso_pkg::SSO_SUPV: begin
        if (tk.us_tick) begin
          tim_next = tim_reg + 32'h00000001;
          if (ramp_en_reg) begin
            lim_next = (lim_reg > dec_x) ? lim_reg - dec_x : '0;
          end
        end
        if (ramp_en_reg) begin
          if (speed_x < tol_x) begin
            if (tk.us_tick) begin
              erl_next = erl_reg + 32'h00000001;
            end
          end else begin
            erl_next = '0;
          end
        end
        if (ramp_en_reg && (!encoder_ok_i || speed_x > lim_reg)) begin
          st_next = sso_pkg::SSO_FAIL;
        end else if (tim_reg >= tmon_reg) begin
          st_next = sso_pkg::SSO_SAFE;
        end else if (ramp_en_reg && ramp_done) begin
          st_next = sso_pkg::SSO_SAFE;
        end else if (ramp_en_reg && early_en_reg && speed_x < tol_x && erl_reg >= terl_reg) begin
          st_next = sso_pkg::SSO_SAFE;
        end
      end
      sso_pkg::SSO_SAFE: begin
        phi_next = 1'b0;
        plo_next = 1'b0;
        if (!stop_req_i) begin
          st_next = sso_pkg::SSO_IDLE;
        end
      end
      sso_pkg::SSO_FAIL: begin
        phi_next = 1'b0;
        plo_next = 1'b0;
        if (ack_i && !viol && !stop_req_i) begin
          st_next = sso_pkg::SSO_IDLE;
        end
      end
      default: begin
        st_next = sso_pkg::SSO_FAIL;
      end
    endcase
    if (viol && st_reg != sso_pkg::SSO_FAIL) begin
      st_next  = sso_pkg::SSO_FAIL;
      phi_next = 1'b0;
      plo_next = 1'b0;
    end
    if (st_next == sso_pkg::SSO_FAIL || st_next == sso_pkg::SSO_SAFE) begin
      phi_next = 1'b0;
      plo_next = 1'b0;
    end
    safe_next = !phi_reg && !plo_reg && st_reg == sso_pkg::SSO_SAFE;
    nfe_next  = (st_next != sso_pkg::SSO_FAIL);
    fail_next = (st_next == sso_pkg::SSO_FAIL);
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_reg   <= sso_pkg::SSO_IDLE;
      tim_reg  <= '0;
      erl_reg  <= '0;
      lim_reg  <= '0;
      phi_reg  <= 1'b1;
      plo_reg  <= 1'b1;
      safe_reg <= 1'b0;
      nfe_reg  <= 1'b1;
      fail_reg <= 1'b0;
    end else begin
      st_reg   <= st_next;
      tim_reg  <= tim_next;
      erl_reg  <= erl_next;
      lim_reg  <= lim_next;
      phi_reg  <= phi_next;
      plo_reg  <= plo_next;
      safe_reg <= safe_next;
      nfe_reg  <= nfe_next;
      fail_reg <= fail_next;
    end
  end

  // ***********************************************
  // read port
  // ***********************************************
  always_comb begin
    rdata_next = 32'h00000000;
    if (rd_i) begin
      case (addr_i)
        A_SLOPE: rdata_next = slope_reg;
        A_CTRL:  rdata_next = {30'h00000000, early_en_reg, ramp_en_reg};
        A_TMON:  rdata_next = tmon_reg;
        A_TDLY:  rdata_next = tdly_reg;
        A_TERL:  rdata_next = terl_reg;
        A_STAT:  rdata_next = {25'h0000000, st_reg, plo_reg, phi_reg, nfe_reg, safe_reg};
        A_TOL:   rdata_next = 32'(tol_reg);
        default: rdata_next = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_reg <= 32'h00000000;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign rdata_o                   = rdata_reg;
  assign pulse_hi_en_o             = phi_reg;
  assign pulse_lo_en_o             = plo_reg;
  assign safe_state_o              = safe_reg;
  assign no_functional_error_out_o = nfe_reg;
  assign fail_o                    = fail_reg;
endmodule

// ---- testbench/sso_chk_monitor.sv ----
`timescale 1ns/1ps
module sso_chk (
  input wire logic        clk_i,
  input wire logic        arst_n_i,
  input wire logic [7:0]  addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic        wr_i,
  input wire logic        stop_req_i,
  input wire logic        ack_i,
  input wire logic        encoder_ok_i,
  input wire logic        standstill_viol_i,
  input wire logic        pulse_hi_en_o,
  input wire logic        pulse_lo_en_o,
  input wire logic        safe_state_o,
  input wire logic        no_functional_error_out_o,
  input wire logic        fail_o
);
  // ****************
  // ramp mode shadow
  // ****************
  logic ramp_en_reg;
  logic ramp_en_next;
  always_comb begin
    ramp_en_next = ramp_en_reg;
    if (wr_i && addr_i == 8'h04) begin
      ramp_en_next = wdata_i[0];
    end
  end
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ramp_en_reg <= 1'b1;
    end else begin
      ramp_en_reg <= ramp_en_next;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  // **********
  // properties
  // **********
  pulse_pair_a: assert property (pulse_hi_en_o == pulse_lo_en_o)
    else $error("pulse outputs differ");
  safe_zero_a: assert property (safe_state_o |-> !pulse_hi_en_o && !pulse_lo_en_o)
    else $error("safe bit with pulses on");
  safe_late_a: assert property ($fell(pulse_hi_en_o) && !fail_o |=> safe_state_o)
    else $error("safe bit missing");
  nfe_fail_a: assert property (no_functional_error_out_o == !fail_o)
    else $error("error output wrong");
  fail_off_a: assert property (fail_o |-> !pulse_hi_en_o)
    else $error("pulses on in error");
  viol_fail_a: assert property (standstill_viol_i |=> fail_o)
    else $error("violation not latched");
  fail_hold_a: assert property (fail_o && !ack_i |=> fail_o)
    else $error("error left without ack");
  fail_keep_a: assert property (fail_o && (standstill_viol_i || stop_req_i) |=> fail_o)
    else $error("error left while blocked");
  enc_fail_a: assert property ($rose(stop_req_i) && ramp_en_reg && !encoder_ok_i |=> fail_o)
    else $error("encoder fault ignored");
  cover property ($rose(safe_state_o));
  cover property ($rose(fail_o));
  cover property ($fell(fail_o));
endmodule
bind sso_monitor sso_chk u_chk (.clk_i(clk_i), .arst_n_i(arst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .wr_i(wr_i), .stop_req_i(stop_req_i), .ack_i(ack_i), .encoder_ok_i(encoder_ok_i),
  .standstill_viol_i(standstill_viol_i), .pulse_hi_en_o(pulse_hi_en_o), .pulse_lo_en_o(pulse_lo_en_o),
  .safe_state_o(safe_state_o), .no_functional_error_out_o(no_functional_error_out_o), .fail_o(fail_o));

// ---- testbench/sso_drive_model.sv ----
`timescale 1ns/1ps
module sso_drive_model (
  input  wire logic        clk_i,
  input  wire logic        arst_n_i,
  input  wire logic        stop_req_i,
  input  wire logic        slow_i,
  output logic      [31:0] speed_o
);
  // the drive itself brakes; slow_i makes it ignore the stop
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      speed_o <= 32'h00003000;
    end else if (!stop_req_i) begin
      speed_o <= 32'h00003000;
    end else if (!slow_i) begin
      speed_o <= (speed_o > 32'h00000100) ? speed_o - 32'h00000100 : 32'h00000000;
    end
  end
endmodule

// ---- testbench/sso_monitor_tb.sv ----
`timescale 1ns/1ps
module sso_monitor_tb;
  logic        clk_i = 1'b0;
  logic        arst_n_i;
  logic [7:0]  addr_i;
  logic [31:0] wdata_i;
  logic        wr_i;
  logic        rd_i;
  logic [31:0] rdata_o;
  logic        stop_req_i;
  logic        ack_i;
  logic        enc_ok;
  logic        viol;
  logic        slow;
  logic [31:0] speed;
  logic        phi;
  logic        plo;
  logic        safe;
  logic        nfe;
  logic        fail_o;
  int          mismatches;
  int          checked;
  always #50 clk_i = ~clk_i;
  sso_monitor uut (.clk_i(clk_i), .arst_n_i(arst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .stop_req_i(stop_req_i), .ack_i(ack_i), .speed_i(speed),
    .speed_limit_i(32'h00004000), .encoder_ok_i(enc_ok), .standstill_viol_i(viol), .pulse_hi_en_o(phi),
    .pulse_lo_en_o(plo), .safe_state_o(safe), .no_functional_error_out_o(nfe), .fail_o(fail_o));
  sso_drive_model u_drive (.clk_i(clk_i), .arst_n_i(arst_n_i), .stop_req_i(stop_req_i), .slow_i(slow),
    .speed_o(speed));
  // *****
  // tasks
  // *****
  task give_verdict;
    $display("checked=%0d mismatches=%0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task chk_word(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task chk_bit(input logic got, input logic exp);
    chk_word({31'h0, got}, {31'h0, exp});
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 chk_word(rdata_o, e);
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task stop(input logic v);
    @(posedge clk_i);
    stop_req_i <= v;
  endtask
  task ack_pulse;
    @(posedge clk_i);
    ack_i <= 1'b1;
    @(posedge clk_i);
    ack_i <= 1'b0;
  endtask
  // sel 0 waits for the safe bit, 1 for the error flag
  task wait_on(input int sel, input int lim);
    int n;
    n = 0;
    #1;
    while (((sel == 0) ? safe : fail_o) !== 1'b1) begin
      if (n == lim) begin
        mismatches++;
        give_verdict();
      end
      n++;
      cyc(1);
    end
  endtask
  // ********
  // sequence
  // ********
  initial begin
    arst_n_i = 1'b0; addr_i = 8'h00; wdata_i = 32'h0; wr_i = 1'b0; rd_i = 1'b0;
    stop_req_i = 1'b0; ack_i = 1'b0; enc_ok = 1'b1; viol = 1'b0; slow = 1'b0; mismatches = 0; checked = 0;
    repeat (16) @(posedge clk_i);
    arst_n_i <= 1'b1;
    rd(8'h00, 32'h3fff0001);
    rd(8'h04, 32'h00000001);
    for (int i = 0; i < 3; i++) rd(8'h08 + 8'(4 * i), 32'h0);
    rd(8'hfc, 32'h0);
    rd(8'h14, 32'h0000000e);
    // time budget only, no encoder and a drive that never brakes
    wr(8'h04, 32'h0); wr(8'h0c, 32'h3); wr(8'h08, 32'h5);
    @(posedge clk_i); enc_ok <= 1'b0; slow <= 1'b1;
    stop(1'b1);
    cyc(55); chk_bit(phi, 1'b1);
    wait_on(0, 40);
    rd(8'h14, 32'h00000033);
    stop(1'b0); cyc(3); chk_bit(phi, 1'b1);
    // ramp supervision, ramp hits zero long before the budget
    wr(8'h04, 32'h1); wr(8'h0c, 32'h0); wr(8'h08, 32'd1000);
    @(posedge clk_i); enc_ok <= 1'b1; slow <= 1'b0;
    stop(1'b1);
    cyc(100); chk_bit(phi, 1'b1);
    wait_on(0, 300); chk_bit(fail_o, 1'b0);
    stop(1'b0); cyc(3);
    // early end once speed stays under tolerance
    wr(8'h18, 32'h100); wr(8'h10, 32'h2); wr(8'h04, 32'h3);
    stop(1'b1); wait_on(0, 115);
    stop(1'b0); cyc(3);
    // drive ignores the stop, ramp is crossed
    wr(8'h04, 32'h1); @(posedge clk_i); slow <= 1'b1;
    stop(1'b1); cyc(20); chk_bit(fail_o, 1'b0);
    wait_on(1, 100); chk_bit(nfe, 1'b0);
    ack_pulse(); cyc(2); chk_bit(fail_o, 1'b1);
    stop(1'b0); ack_pulse(); cyc(2); chk_bit(fail_o, 1'b0);
    // encoder missing at request in ramp mode
    @(posedge clk_i); slow <= 1'b0; enc_ok <= 1'b0;
    stop(1'b1); cyc(3); chk_bit(fail_o, 1'b1);
    stop(1'b0); enc_ok <= 1'b1; ack_pulse(); cyc(2); chk_bit(fail_o, 1'b0);
    // standstill violation while idle
    @(posedge clk_i); viol <= 1'b1;
    cyc(2); chk_bit(fail_o, 1'b1); chk_bit(phi, 1'b0);
    chk_bit(plo, 1'b0);
    ack_pulse(); cyc(1); chk_bit(fail_o, 1'b1);
    @(posedge clk_i); viol <= 1'b0;
    ack_pulse(); cyc(2); chk_bit(fail_o, 1'b0); chk_bit(phi, 1'b1);
    give_verdict();
  end
endmodule
